// File: wake_cfg_pkg.sv
package wake_cfg_pkg;

  // Register addresses (7-bit serial interface address space)
  localparam logic [6:0] ADDR_CONTROL      = 7'h20;
  localparam logic [6:0] ADDR_BIT_QUANTA   = 7'h21;
  localparam logic [6:0] ADDR_SAMPLE_POINT = 7'h22;
  localparam logic [6:0] ADDR_ID_BYTE3     = 7'h23;
  localparam logic [6:0] ADDR_ID_BYTE2     = 7'h24;
  localparam logic [6:0] ADDR_ID_BYTE1     = 7'h25;
  localparam logic [6:0] ADDR_ID_BYTE0     = 7'h26;

  // Control register field positions
  localparam int CTRL_OSC_TRIM_BIT   = 7;
  localparam int CTRL_UNLOCK_HI      = 6;
  localparam int CTRL_UNLOCK_LO      = 5;
  localparam int CTRL_TO_MASK_BIT    = 4;
  localparam int CTRL_VALID_BIT      = 0;
  localparam logic [1:0] UNLOCK_KEY  = 2'h3;

  // Writable bit masks, everything else reads zero; then the restart keep mask
  localparam logic [7:0] CTRL_WR_MASK   = 8'hF1;
  localparam logic [7:0] SP_WR_MASK     = 8'h3F;
  localparam logic [7:0] ID0_WR_MASK    = 8'h7F;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'hF0;

  // Lowest identifier register field positions
  localparam int ID0_LO_HI     = 6;
  localparam int ID0_LO_LO     = 2;
  localparam int ID0_RTR_BIT   = 1;
  localparam int ID0_EXT_BIT   = 0;

  // Values after power-on or soft reset
  localparam logic [7:0] RST_CONTROL      = 8'h00;
  localparam logic [7:0] RST_BIT_QUANTA   = 8'hA0;
  localparam logic [7:0] RST_SAMPLE_POINT = 8'h33;
  localparam logic [7:0] RST_ID           = 8'h00;

  // Option register write window: strobe length in cycles
  localparam int OPT_WR_PULSE_CYCLES = 1;

endpackage : wake_cfg_pkg

// File: timeout_irq_gate.sv
`timescale 1ns/100ps
// Sticky time-out flag and its gated interrupt request
module timeout_irq_gate
  import wake_cfg_pkg::*;
(
  input  wire logic ref_clk,       // System clock
  input  wire logic rstn,          // Synchronous reset, active low
  input  wire logic wake_active,   // Selective wake currently enabled
  input  wire logic mode_ok,       // Normal or stop mode
  input  wire logic timeout_evt,   // Bus time-out event pulse
  input  wire logic flag_clear,    // Clear request from bus_timeout_clr
  input  wire logic irq_mask,      // 1 lets the time-out reach the pin
  output logic      flag,          // Sticky time-out flag
  output logic      irq_req        // One-cycle interrupt request
);

  typedef struct packed {
    logic flag;
    logic irq;
  } gate_s;

  gate_s st;
  gate_s next_st;

  // Flag only sets while wake is on; set beats a same-cycle clear
  always_comb begin
    next_st     = st;
    next_st.irq = 1'b0;
    if (flag_clear) begin
      next_st.flag = 1'b0;
    end
    if (wake_active && timeout_evt) begin
      next_st.flag = 1'b1;
      // Mask gates the pin, not the flag
      next_st.irq  = irq_mask && mode_ok;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag    = st.flag;
  assign irq_req = st.irq;

endmodule : timeout_irq_gate

// File: can_selective_wake_config_bank.sv
`timescale 1ns/100ps
// Functional notes
// - Control bit 7 enables oscillator trim mode
// - Unlock field 6:5 unlocks only at 11
// - Trim uses bus transmit input as reference
// - Unlock pattern also gates option register writes
// - Bit 4 masks time-out interrupt output
// - Time-out flag sets only while wake enabled
// - Wake enabled only while config-valid reads one
// - Valid clears on wake, reset, config change
// - Reserved bits read zero, ignore writes
// - Bit quanta register holds quanta per bit
// - Sample point register holds six-bit fraction
// - Power-on/soft reset loads A0, 33, zeros
// - Restart keeps control upper nibble only
// - Identifier split over four registers
// - Byte0 bit 1 selects remote request
// - Byte0 bit 0 selects extended identifier
module can_selective_wake_config_bank
  import wake_cfg_pkg::*;
(
  input  wire logic        ref_clk,            // System clock, 100 MHz
  input  wire logic        rstn,               // Power-on/soft reset, low
  input  wire logic        restart_req,        // Restart pulse
  input  wire logic        reg_wr,             // Register write strobe
  input  wire logic        reg_rd,             // Register read strobe
  input  wire logic [6:0]  reg_addr,           // Register address
  input  wire logic [7:0]  reg_wdata,          // Write data
  input  wire logic        wake_event,         // Wake-up detected pulse
  input  wire logic        bus_timeout_evt,    // Bus time-out pulse
  input  wire logic        bus_timeout_clr,    // Clear time-out flag
  input  wire logic        mode_normal_stop,   // Normal or stop mode
  input  wire logic        bus_transmit_input, // Controller transmit data
  output logic [7:0]       reg_rdata,          // Read data
  output logic             reg_rvalid,         // Read data valid pulse
  output logic             osc_trim_mode,      // Trim mode enabled
  output logic             osc_trim_unlocked,  // Recalibration unlocked
  output logic             osc_trim_active,    // Trim running
  output logic             osc_trim_ref,       // Trim reference level
  output logic             lowpower_opt_wr,    // Option register write
  output logic [7:0]       lowpower_opt_wdata, // Option register data
  output logic             selective_wake,     // Selective wake enabled
  output logic             bus_timeout_flag,   // Sticky time-out flag
  output logic             interrupt_out_n,    // Interrupt pin, low
  output logic [7:0]       quanta_per_bit,     // Quanta per bit time
  output logic [5:0]       sample_point_frac,  // Sample point fraction
  output logic [28:0]      wake_ident,         // Full wake identifier
  output logic             wake_frame_rtr,     // Expect remote frame
  output logic             wake_frame_ext      // Extended identifier
);

  // Write strobe into the option register lasts this many cycles
  if (OPT_WR_PULSE_CYCLES != 1) begin : g_pulse_chk
    $error("Option write strobe must be one cycle");
  end

  // Every register of the bank except the time-out gate's lives in one struct
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] bit_quanta;
    logic [7:0] sample_pt;
    logic [7:0] id3;
    logic [7:0] id2;
    logic [7:0] id1;
    logic [7:0] id0;
    logic [7:0] rdata;
    logic       rvalid;
    logic       opt_wr;
    logic [7:0] opt_wdata;
    logic       wake_on;
    logic       trim_unlocked;
    logic       trim_active;
    logic       trim_ref;
    logic       irq_n;
  } bank_s;

  bank_s st;
  bank_s next_st;

  logic to_flag;   // Sticky time-out flag from the gate
  logic to_irq;    // One-cycle interrupt request from the gate

  // Unlock decode shared by trim and option-write gating
  function automatic logic key_ok(input logic [7:0] ctrl);
    key_ok = (ctrl[CTRL_UNLOCK_HI:CTRL_UNLOCK_LO] == UNLOCK_KEY);
  endfunction : key_ok

  // Read mux: unmapped addresses read zero
  function automatic logic [7:0] read_reg(input bank_s s,
                                          input logic [6:0] a);
    unique case (a)
      ADDR_CONTROL:      read_reg = s.control & CTRL_WR_MASK;
      ADDR_BIT_QUANTA:   read_reg = s.bit_quanta;
      ADDR_SAMPLE_POINT: read_reg = s.sample_pt & SP_WR_MASK;
      ADDR_ID_BYTE3:     read_reg = s.id3;
      ADDR_ID_BYTE2:     read_reg = s.id2;
      ADDR_ID_BYTE1:     read_reg = s.id1;
      ADDR_ID_BYTE0:     read_reg = s.id0 & ID0_WR_MASK;
      default:           read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // Time-out flag and its interrupt gating live in a small leaf
  timeout_irq_gate u_timeout (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .wake_active (st.wake_on),
    .mode_ok     (mode_normal_stop),
    .timeout_evt (bus_timeout_evt),
    .flag_clear  (bus_timeout_clr),
    .irq_mask    (st.control[CTRL_TO_MASK_BIT]),
    .flag        (to_flag),
    .irq_req     (to_irq)
  );

  // Next-state logic for the whole bank
  always_comb begin
    logic cfg_change;
    logic [7:0] wmasked;
    cfg_change        = 1'b0;
    wmasked           = 8'h00;
    next_st           = st;
    next_st.rvalid    = 1'b0;
    next_st.opt_wr    = 1'b0;
    // Register writes; reserved bits are dropped at the door
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CONTROL: begin
          wmasked = reg_wdata & CTRL_WR_MASK;
          next_st.control = wmasked;
        end
        ADDR_BIT_QUANTA: begin
          cfg_change = (reg_wdata != st.bit_quanta);
          next_st.bit_quanta = reg_wdata;
        end
        ADDR_SAMPLE_POINT: begin
          wmasked = reg_wdata & SP_WR_MASK;
          cfg_change = (wmasked != st.sample_pt);
          next_st.sample_pt = wmasked;
        end
        ADDR_ID_BYTE3: begin
          cfg_change = (reg_wdata != st.id3);
          next_st.id3 = reg_wdata;
        end
        ADDR_ID_BYTE2: begin
          cfg_change = (reg_wdata != st.id2);
          next_st.id2 = reg_wdata;
        end
        ADDR_ID_BYTE1: begin
          cfg_change = (reg_wdata != st.id1);
          next_st.id1 = reg_wdata;
        end
        ADDR_ID_BYTE0: begin
          wmasked = reg_wdata & ID0_WR_MASK;
          cfg_change = (wmasked != st.id0);
          next_st.id0 = wmasked;
        end
        default: begin
          // Option register is outside the bank; pass it on if unlocked
          if (key_ok(st.control)) begin
            next_st.opt_wr    = 1'b1;
            next_st.opt_wdata = reg_wdata;
          end
        end
      endcase
    end
    // Any changed wake data or a wake-up drops the valid bit
    if (cfg_change || wake_event) begin
      next_st.control[CTRL_VALID_BIT] = 1'b0;
    end
    // Restart keeps the upper nibble only; other registers hold
    if (restart_req) begin
      next_st.control = st.control & CTRL_KEEP_MASK;
    end
    // Selective wake follows the stored valid bit
    next_st.wake_on  = next_st.control[CTRL_VALID_BIT];
    // Trim decode registered so the pins come straight from flops
    next_st.trim_unlocked = key_ok(next_st.control);
    next_st.trim_active   = next_st.control[CTRL_OSC_TRIM_BIT]
                            && next_st.trim_unlocked;
    // Trim reference is the transmit pin, only while trim is on
    next_st.trim_ref = next_st.trim_active && bus_transmit_input;
    // Interrupt pin pulses low for one cycle per signalled time-out
    next_st.irq_n    = !to_irq;
    // Read data registered one cycle after the strobe
    if (reg_rd) begin
      next_st.rdata  = read_reg(st, reg_addr);
      next_st.rvalid = 1'b1;
    end
  end

  // Bank register; reset loads the power-on values
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st            <= '0;
      st.control    <= RST_CONTROL;
      st.bit_quanta <= RST_BIT_QUANTA;
      st.sample_pt  <= RST_SAMPLE_POINT;
      st.id3        <= RST_ID;
      st.id2        <= RST_ID;
      st.id1        <= RST_ID;
      st.id0        <= RST_ID;
      st.irq_n      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata          = st.rdata;
  assign reg_rvalid         = st.rvalid;
  assign osc_trim_mode      = st.control[CTRL_OSC_TRIM_BIT];
  assign osc_trim_unlocked  = st.trim_unlocked;
  assign osc_trim_active    = st.trim_active;
  assign osc_trim_ref       = st.trim_ref;
  assign lowpower_opt_wr    = st.opt_wr;
  assign lowpower_opt_wdata = st.opt_wdata;
  assign selective_wake     = st.wake_on;
  assign bus_timeout_flag   = to_flag;
  assign interrupt_out_n    = st.irq_n;
  assign quanta_per_bit     = st.bit_quanta;
  assign sample_point_frac  = st.sample_pt[5:0];
  // Standard identifiers occupy the top eleven bits
  assign wake_ident = {st.id3, st.id2, st.id1,
                       st.id0[ID0_LO_HI:ID0_LO_LO]};
  assign wake_frame_rtr     = st.id0[ID0_RTR_BIT];
  assign wake_frame_ext     = st.id0[ID0_EXT_BIT];

  // Reserved control bits never read back
  property p_ctrl_reserved;
    @(posedge ref_clk) disable iff (!rstn)
      reg_rvalid && $past(reg_addr) == ADDR_CONTROL
      |-> reg_rdata[3:1] == 3'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("Reserved control bits read nonzero");

  // Wake turns on only after the host writes the valid bit
  property p_wake_valid;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(selective_wake) |-> $past(reg_wr)
        && $past(reg_addr) == ADDR_CONTROL
        && $past(reg_wdata[CTRL_VALID_BIT]);
  endproperty
  a_wake_valid: assert property (p_wake_valid)
    else $error("Wake enabled without a valid write");

  // Wake event drops valid next cycle
  property p_wake_clears;
    @(posedge ref_clk) disable iff (!rstn)
      wake_event |=> !selective_wake;
  endproperty
  a_wake_clears: assert property (p_wake_clears)
    else $error("Valid survived a wake event");

  // Changed identifier byte 3 drops valid
  property p_cfg_change;
    @(posedge ref_clk) disable iff (!rstn)
      reg_wr && reg_addr == ADDR_ID_BYTE3 && reg_wdata != st.id3
      |=> !selective_wake;
  endproperty
  a_cfg_change: assert property (p_cfg_change)
    else $error("Valid survived a configuration change");

  // Restart keeps upper nibble, clears lower
  property p_restart;
    @(posedge ref_clk) disable iff (!rstn)
      restart_req |=> st.control[3:0] == 4'h0
        && st.control[7:4] == $past(st.control[7:4]);
  endproperty
  a_restart: assert property (p_restart)
    else $error("Restart handled control register wrongly");

  // Option write only with unlock key
  property p_opt_lock;
    @(posedge ref_clk) disable iff (!rstn)
      lowpower_opt_wr |-> $past(st.control[6:5]) == 2'h3 && $past(reg_wr);
  endproperty
  a_opt_lock: assert property (p_opt_lock)
    else $error("Option write without unlock");

  // Trim reference silent unless trim fully active
  property p_trim_ref;
    @(posedge ref_clk) disable iff (!rstn)
      osc_trim_ref |-> osc_trim_active;
  endproperty
  a_trim_ref: assert property (p_trim_ref)
    else $error("Trim reference without unlocked trim");

  // Interrupt only with mask set and wake enabled
  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rstn)
      !interrupt_out_n |-> $past(st.control[4], 2)
        && $past(selective_wake, 2);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Interrupt raised while masked or wake off");

  // Time-out without wake does not set flag
  property p_flag_hold;
    @(posedge ref_clk) disable iff (!rstn)
      !selective_wake && bus_timeout_evt && !bus_timeout_flag
      |=> !bus_timeout_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Time-out flag set while wake off");

  // Time-out while wake is on always sets the flag
  property p_flag_set;
    @(posedge ref_clk) disable iff (!rstn)
      selective_wake && bus_timeout_evt |=> bus_timeout_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Time-out flag missed while wake on");

  // Restart leaves timing and identifier registers alone
  property p_restart_keeps;
    @(posedge ref_clk) disable iff (!rstn)
      restart_req && !reg_wr
      |=> $stable(quanta_per_bit) && $stable(wake_ident)
        && $stable(sample_point_frac);
  endproperty
  a_restart_keeps: assert property (p_restart_keeps)
    else $error("Restart disturbed a kept register");

  // Reserved sample point bits never read back
  property p_sp_reserved;
    @(posedge ref_clk) disable iff (!rstn)
      reg_rvalid && $past(reg_addr) == ADDR_SAMPLE_POINT
      |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_sp_reserved: assert property (p_sp_reserved)
    else $error("Reserved sample point bits read nonzero");

  // Reserved top bit of the lowest identifier byte never reads back
  property p_id0_reserved;
    @(posedge ref_clk) disable iff (!rstn)
      reg_rvalid && $past(reg_addr) == ADDR_ID_BYTE0
      |-> reg_rdata[7] == 1'b0;
  endproperty
  a_id0_reserved: assert property (p_id0_reserved)
    else $error("Reserved identifier bit read nonzero");

  // Option data is the byte written in the unlocked cycle
  property p_opt_data;
    @(posedge ref_clk) disable iff (!rstn)
      lowpower_opt_wr |-> lowpower_opt_wdata == $past(reg_wdata);
  endproperty
  a_opt_data: assert property (p_opt_data)
    else $error("Option data differs from written byte");

  c_wake_on: cover property (@(posedge ref_clk) $rose(selective_wake));
  c_irq: cover property (@(posedge ref_clk) !interrupt_out_n);
  c_opt: cover property (@(posedge ref_clk) lowpower_opt_wr);
  c_restart: cover property (@(posedge ref_clk) restart_req);

endmodule : can_selective_wake_config_bank

// File: mcu_host_model.sv
`timescale 1ns/100ps
// Microcontroller side of the register bus, one request per task call
module mcu_host_model (
  input  wire logic       ref_clk,    // System clock
  output logic            reg_wr,     // Write strobe
  output logic            reg_rd,     // Read strobe
  output logic [6:0]      reg_addr,   // Register address
  output logic [7:0]      reg_wdata,  // Write data
  input  wire logic [7:0] reg_rdata,  // Read data
  input  wire logic       reg_rvalid  // Read data valid pulse
);
  // Idle bus before the first request
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end

  // Strobe held across one rising edge; released bus shows inverted values
  // so the design can never lean on a stale address or data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Read data and valid are taken in the cycle after the strobe edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : mcu_host_model

// File: test_can_selective_wake_config_bank.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  error_cnt++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, got, exp); \
  end end
module test_can_selective_wake_config_bank;
  import wake_cfg_pkg::*;
  logic        ref_clk, rstn, restart_req, reg_wr, reg_rd;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, lowpower_opt_wdata, quanta_per_bit;
  logic        wake_event, bus_timeout_evt, bus_timeout_clr;
  logic        mode_normal_stop, bus_transmit_input, reg_rvalid;
  logic        osc_trim_mode, osc_trim_unlocked, osc_trim_active;
  logic        osc_trim_ref, lowpower_opt_wr, selective_wake;
  logic        bus_timeout_flag, interrupt_out_n;
  logic        wake_frame_rtr, wake_frame_ext;
  logic [5:0]  sample_point_frac;
  logic [28:0] wake_ident;
  int          error_cnt, checks_done, seed, m[7], lows;
  logic [7:0]  rdv, d;
  logic        ok;

  can_selective_wake_config_bank i_dut (.*);
  mcu_host_model i_mcu (.ref_clk, .reg_wr, .reg_rd, .reg_addr,
                        .reg_wdata, .reg_rdata, .reg_rvalid);

  // Free running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Writable bits of each register, reserved bits dropped
  function automatic int wmask(int i);
    return i == 0 ? CTRL_WR_MASK : i == 2 ? SP_WR_MASK :
           i == 6 ? ID0_WR_MASK : 8'hFF;
  endfunction : wmask

  // Write through the host and mirror the effect in the model
  task automatic wr(int a, int v);
    int i;
    int nv;
    i = a - 'h20;
    nv = v & wmask(i);
    i_mcu.wr(7'(a), 8'(v));
    if (i == 0) m[0] = nv;
    else if (nv != m[i]) begin
      m[0] &= 'hFE;
      m[i] = nv;
    end
  endtask : wr

  // Read one register and compare with the model
  task automatic rd_chk(int i);
    i_mcu.rd(7'('h20 + i), rdv, ok);
    `CHK(ok, 1'b1)
    `CHK(rdv, 8'(m[i]))
  endtask : rd_chk

  // Every configuration output against the model
  task automatic out_chk();
    `CHK(quanta_per_bit, 8'(m[1]))
    `CHK(sample_point_frac, 6'(m[2]))
    `CHK(wake_ident, {8'(m[3]), 8'(m[4]), 8'(m[5]), 5'(m[6] >> 2)})
    `CHK(wake_frame_rtr, 1'(m[6] >> 1))
    `CHK(wake_frame_ext, 1'(m[6]))
    `CHK(selective_wake, 1'(m[0]))
    `CHK(osc_trim_mode, 1'(m[0] >> 7))
    `CHK(osc_trim_unlocked, (m[0] >> 5 & 3) == 3)
    `CHK(osc_trim_active, (m[0] >> 5 & 7) == 7)
  endtask : out_chk

  // One-cycle pulse on a bench-driven input
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask : pulse

  // Verdict, the single end of the run
  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  // Main sequence
  initial begin
    {rstn, restart_req, wake_event, bus_timeout_evt} = '0;
    {bus_timeout_clr, mode_normal_stop, bus_transmit_input} = '0;
    error_cnt = 0;
    checks_done = 0;
    seed = 81880;
    m = '{RST_CONTROL, RST_BIT_QUANTA, RST_SAMPLE_POINT, 0, 0, 0, 0};
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(i);
    i_mcu.rd(7'h10, rdv, ok);
    `CHK(rdv, 8'h00)
    out_chk();
    $display("test reset values done");
    // Random traffic on all registers, reserved bits set on purpose
    repeat (60) begin
      int i;
      i = {$random(seed)} % 7;
      d = 8'($random(seed));
      if (i == 6) d[ID0_RTR_BIT] = 1'b0;
      wr('h20 + i, d);
      out_chk();
      rd_chk({$random(seed)} % 7);
    end
    // Standard identifier placed in the upper eleven bits
    wr('h23, 'h5A3 >> 3);
    wr('h24, ('h5A3 & 7) << 5);
    wr('h25, 0);
    wr('h26, 0);
    `CHK(wake_ident, 29'(11'h5A3) << 18)
    // Remote request set deliberately only to see its decode
    wr('h26, 'h83);
    out_chk();
    $display("test register traffic done");
    // Valid bit: kept on rewrite of same value, dropped on change or wake
    wr('h20, 'h01);
    wr('h21, m[1]);
    out_chk();
    wr('h21, m[1] ^ 'h5A);
    out_chk();
    wr('h20, 'h01);
    pulse(wake_event);
    m[0] &= 'hFE;
    out_chk();
    $display("test valid bit done");
    // Every unlock pattern against an option register write
    for (int k = 0; k < 4; k++) begin
      wr('h20, k << 5);
      i_mcu.wr(7'h30, 8'(8'h3C + k));
      `CHK(lowpower_opt_wr, k == 3)
      if (k == 3) `CHK(lowpower_opt_wdata, 8'h3F)
      `CHK(osc_trim_unlocked, k == 3)
    end
    $display("test unlock done");
    // Trim reference follows the transmit input while trim runs
    wr('h20, 'hE0);
    `CHK(osc_trim_active, 1'b1)
    repeat (12) begin
      @(negedge ref_clk);
      bus_transmit_input = 1'($random(seed));
      @(negedge ref_clk);
      `CHK(osc_trim_ref, bus_transmit_input)
    end
    $display("test trim done");
    // Time-out over all mask, wake and mode combinations
    for (int v = 0; v < 8; v++) begin
      wr('h20, ((v & 1) << 4) | (v >> 1 & 1));
      mode_normal_stop = 1'(v >> 2);
      pulse(bus_timeout_clr);
      `CHK(bus_timeout_flag, 1'b0)
      @(negedge ref_clk);
      bus_timeout_evt = 1'b1;
      lows = 0;
      repeat (4) begin
        @(negedge ref_clk);
        bus_timeout_evt = 1'b0;
        lows += !interrupt_out_n;
      end
      `CHK(bus_timeout_flag, 1'(v >> 1))
      `CHK(lows, int'(v == 7))
    end
    $display("test time-out done");
    // Restart keeps the upper control nibble and all other registers
    wr('h20, 'hF1);
    pulse(restart_req);
    m[0] &= CTRL_KEEP_MASK;
    for (int i = 0; i < 7; i++) rd_chk(i);
    out_chk();
    $display("test restart done");
    // Soft reset after traffic reloads every power-on value
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    m = '{RST_CONTROL, RST_BIT_QUANTA, RST_SAMPLE_POINT, 0, 0, 0, 0};
    for (int i = 0; i < 7; i++) rd_chk(i);
    out_chk();
    $display("test soft reset done");
    results();
  end
endmodule : test_can_selective_wake_config_bank
